// ==== shared/uotg_regs.svh ====
// register map, field masks and timing counts of the usb interrupt flag block
// assumes a 25 MHz bus clock and 32-bit word-aligned registers
`ifndef UOTG_REGS_SVH
`define UOTG_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UOTG_OFF_OTG_IR 32'h0000_0000
`define UOTG_OFF_OTG_IE 32'h0000_0004
`define UOTG_OFF_USB_IR 32'h0000_0008
`define UOTG_OFF_USB_IE 32'h0000_000c
`define UOTG_OFF_ERR_IE 32'h0000_0010

// ----------------------------------------------------------------
// register indices after decode
// ----------------------------------------------------------------
`define UOTG_IDX_OTG_IR 3'h0
`define UOTG_IDX_OTG_IE 3'h1
`define UOTG_IDX_USB_IR 3'h2
`define UOTG_IDX_USB_IE 3'h3
`define UOTG_IDX_ERR_IE 3'h4
`define UOTG_IDX_NONE 3'h7

// ----------------------------------------------------------------
// implemented bits and field positions
// ----------------------------------------------------------------
`define UOTG_OTG_MASK 8'hfd
`define UOTG_ERR_MASK 8'hbf
`define UOTG_USB_W1C_MASK 8'hfd
`define UOTG_HOST_ONLY 8'h40
`define UOTG_B_ATTACH 6
`define UOTG_B_RESUME 5
`define UOTG_B_TOKEN 3
`define UOTG_B_ERRSUM 1
`define UOTG_RST_BYTE 8'h00

// ----------------------------------------------------------------
// line states on {dp, dm}
// ----------------------------------------------------------------
`define UOTG_LINE_DIFF1 2'h2
`define UOTG_LINE_DIFF0 2'h1
`define UOTG_LINE_SE0 2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define UOTG_CLK_HZ 25000000
`define UOTG_T_SHORT_NS 2500
`define UOTG_T_STABLE_US 1000
`define UOTG_T_IDLE_US 3000
`define UOTG_CYC_SHORT 17'((`UOTG_T_SHORT_NS * (`UOTG_CLK_HZ / 1000000) + 999) / 1000)
`define UOTG_CYC_STABLE 17'(`UOTG_T_STABLE_US * (`UOTG_CLK_HZ / 1000000))
`define UOTG_CYC_IDLE 17'(`UOTG_T_IDLE_US * (`UOTG_CLK_HZ / 1000000))

`endif

// ==== shared/uotg_pkg.sv ====
// types of the usb interrupt flag block
// assumes the constants of uotg_regs.svh
package uotg_pkg;

	// ----------------------------------------------------------------
	// bus data phase
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		UOTG_PH_IDLE,
		UOTG_PH_WRITE,
		UOTG_PH_READ
	} uotg_phase_t;

	// ----------------------------------------------------------------
	// state of the register core
	// ----------------------------------------------------------------
	typedef struct packed {
		uotg_phase_t phase;
		logic [2:0] widx;
		logic [7:0] otg_ir;
		logic [7:0] otg_ie;
		logic [7:0] usb_ir;
		logic [7:0] usb_ie;
		logic [7:0] err_ie;
		logic err_sum;
		logic usb_irq;
		logic otg_irq;
		logic fifo_adv;
		logic ready;
		logic resp;
		logic [31:0] rdata;
	} uotg_core_t;

	// ----------------------------------------------------------------
	// state of the line detector
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] last_line;
		logic [1:0] stable_line;
		logic [4:0][16:0] cnt;
		logic [4:0] hit;
	} uotg_det_t;

endpackage

// ==== shared/uotg_line_if.sv ====
// conditions passed from the line detector to the register core
// assumes both ends on the same clock; every signal is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

interface uotg_line_if;
	logic resume_hit;
	logic se0_hit;
	logic quiet_hit;
	logic idle_hit;
	logic stable_hit;

	modport detector (output resume_hit, se0_hit, quiet_hit, idle_hit, stable_hit);
	modport core (input resume_hit, se0_hit, quiet_hit, idle_hit, stable_hit);
endinterface

`default_nettype wire

// ==== design/uotg_line_det.sv ====
// line-state timers: resume, long se0, quiet bus, idle and stable line
// assumes dp/dm synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
`include "uotg_regs.svh"

module uotg_line_det #(
	parameter logic [16:0] CYC_STABLE = `UOTG_CYC_STABLE,
	parameter logic [16:0] CYC_IDLE = `UOTG_CYC_IDLE
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus line levels
	input wire logic line_dp,
	input wire logic line_dm,
	input wire logic low_speed,
	// detected conditions
	uotg_line_if.detector det
);
	import uotg_pkg::*;

	uotg_det_t st;
	uotg_det_t next_st;
	logic [1:0] line;
	logic se0;
	logic kst;
	logic jst;
	logic same;
	logic [4:0] run;
	logic [4:0][16:0] lim;

	// saturating run counter, cleared when the condition drops
	function automatic logic [16:0] uotg_count(input logic [16:0] cur, input logic go,
			input logic [16:0] top);
		if (!go) begin
			return 17'h00000;
		end else if (cur == top) begin
			return cur;
		end
		return cur + 17'h00001;
	endfunction

	// ----------------------------------------------------------------
	// detectors
	// ----------------------------------------------------------------
	// slot 0 k-state, 1 se0, 2 quiet non-se0, 3 idle j-state, 4 stable line
	always_comb begin
		line = {line_dp, line_dm};
		se0 = line == `UOTG_LINE_SE0;
		kst = low_speed ? (line == `UOTG_LINE_DIFF1) : (line == `UOTG_LINE_DIFF0);
		jst = low_speed ? (line == `UOTG_LINE_DIFF0) : (line == `UOTG_LINE_DIFF1);
		same = line == st.last_line;
		run = {same, jst, ~se0 & same, se0, kst};
		lim = {CYC_STABLE, CYC_IDLE, `UOTG_CYC_SHORT, `UOTG_CYC_SHORT, `UOTG_CYC_SHORT};
		next_st = st;
		next_st.last_line = line;
		for (int i = 0; i < 5; i++) begin
			next_st.cnt[i] = uotg_count(st.cnt[i], run[i], lim[i]);
			next_st.hit[i] = run[i] && (st.cnt[i] == lim[i] - 17'h00001);
		end
		next_st.hit[4] = next_st.hit[4] && (line != st.stable_line);
		if (next_st.hit[4]) begin
			next_st.stable_line = line;
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// pulses out
	assign det.resume_hit = st.hit[0];
	assign det.se0_hit = st.hit[1];
	assign det.quiet_hit = st.hit[2];
	assign det.idle_hit = st.hit[3];
	assign det.stable_hit = st.hit[4];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_RESUME_TIME: assert property (@(posedge hclk) disable iff (!hresetn)
		st.hit[0] |-> $past(kst) && $past(st.cnt[0]) == `UOTG_CYC_SHORT - 17'h00001)
		else $error("resume pulse without full k-state time");
	AST_SE0_ONCE: assert property (@(posedge hclk) disable iff (!hresetn)
		(se0 && st.cnt[1] == `UOTG_CYC_SHORT) |=> !st.hit[1])
		else $error("long se0 reported twice in one reset");
	AST_IDLE_TIME: assert property (@(posedge hclk) disable iff (!hresetn)
		st.hit[3] |-> $past(st.cnt[3]) == CYC_IDLE - 17'h00001)
		else $error("idle pulse before idle time");
endmodule

`default_nettype wire

// ==== design/uotg_irq_core.sv ====
// usb otg interrupt flags and enables behind an ahb-lite slave
// assumes event inputs are one-cycle pulses synchronous to hclk
//
// Chosen here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "uotg_regs.svh"

module uotg_irq_core #(
	parameter logic [16:0] CYC_STABLE = `UOTG_CYC_STABLE,
	parameter logic [16:0] CYC_IDLE = `UOTG_CYC_IDLE
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// mode and line
	input wire logic host_mode,
	input wire logic low_speed,
	input wire logic line_dp,
	input wire logic line_dm,
	// events from the packet engine and otg logic
	input wire logic stall_sent,
	input wire logic token_done,
	input wire logic sof_rx,
	input wire logic sof_thresh,
	input wire logic id_change,
	input wire logic ms_tick,
	input wire logic bus_activity,
	input wire logic sess_valid_chg,
	input wire logic sess_end_chg,
	input wire logic vbus_valid_chg,
	input wire logic [7:0] err_flags,
	// requests
	output logic usb_irq,
	output logic otg_irq,
	output logic fifo_advance
);
	import uotg_pkg::*;

	uotg_core_t st;
	uotg_core_t next_st;
	uotg_line_if lif ();
	logic take;
	logic wr;
	logic [2:0] aidx;
	logic [7:0] usb_set;
	logic [7:0] otg_set;
	logic [7:0] wbyte;
	logic [7:0] rd;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte address to register index
	function automatic logic [2:0] uotg_decode(input logic [31:0] a);
		if (a == `UOTG_OFF_OTG_IR) begin
			return `UOTG_IDX_OTG_IR;
		end else if (a == `UOTG_OFF_OTG_IE) begin
			return `UOTG_IDX_OTG_IE;
		end else if (a == `UOTG_OFF_USB_IR) begin
			return `UOTG_IDX_USB_IR;
		end else if (a == `UOTG_OFF_USB_IE) begin
			return `UOTG_IDX_USB_IE;
		end else if (a == `UOTG_OFF_ERR_IE) begin
			return `UOTG_IDX_ERR_IE;
		end
		return `UOTG_IDX_NONE;
	endfunction

	// status as software sees it in the current mode
	function automatic logic [7:0] uotg_usb_view(input logic [7:0] ir, input logic es,
			input logic host);
		logic [7:0] v;
		v = ir;
		v[`UOTG_B_ERRSUM] = es;
		if (!host) begin
			v = v & ~`UOTG_HOST_ONLY;
		end
		return v;
	endfunction

	// enables as software sees them in the current mode
	function automatic logic [7:0] uotg_ie_view(input logic [7:0] ie, input logic host);
		return host ? ie : (ie & ~`UOTG_HOST_ONLY);
	endfunction

	// ----------------------------------------------------------------
	// line detector
	// ----------------------------------------------------------------
	uotg_line_det #(
		.CYC_STABLE(CYC_STABLE),
		.CYC_IDLE(CYC_IDLE)
	) u_det (
		.hclk(hclk),
		.hresetn(hresetn),
		.line_dp(line_dp),
		.line_dm(line_dm),
		.low_speed(low_speed),
		.det(lif.detector)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.ready = 1'b1;
		next_st.fifo_adv = 1'b0;
		// hardware set sources per flag position
		usb_set = {stall_sent & ~host_mode,
			host_mode & lif.quiet_hit,
			lif.resume_hit,
			lif.idle_hit,
			token_done,
			host_mode ? sof_thresh : sof_rx,
			1'b0,
			lif.se0_hit};
		otg_set = {id_change, ms_tick, lif.stable_hit, bus_activity, sess_valid_chg,
			sess_end_chg, 1'b0, vbus_valid_chg};
		wr = st.phase == UOTG_PH_WRITE;
		wbyte = hwdata[7:0];
		// flags only ever gain bits from hardware
		next_st.usb_ir = st.usb_ir | usb_set;
		next_st.otg_ir = st.otg_ir | otg_set;
		// data phase write; set wins over clear
		if (wr) begin
			if (st.widx == `UOTG_IDX_OTG_IR) begin
				next_st.otg_ir = (st.otg_ir & ~(wbyte & `UOTG_OTG_MASK)) | otg_set;
			end else if (st.widx == `UOTG_IDX_OTG_IE) begin
				next_st.otg_ie = wbyte & `UOTG_OTG_MASK;
			end else if (st.widx == `UOTG_IDX_USB_IR) begin
				next_st.usb_ir = (st.usb_ir & ~(wbyte & `UOTG_USB_W1C_MASK)) | usb_set;
				next_st.fifo_adv = wbyte[`UOTG_B_TOKEN] & st.usb_ir[`UOTG_B_TOKEN];
			end else if (st.widx == `UOTG_IDX_USB_IE) begin
				next_st.usb_ie = uotg_ie_view(wbyte, host_mode);
			end else if (st.widx == `UOTG_IDX_ERR_IE) begin
				next_st.err_ie = wbyte & `UOTG_ERR_MASK;
			end
		end
		// error summary follows enabled error flags only
		next_st.err_sum = |(err_flags & st.err_ie & `UOTG_ERR_MASK);
		// requests
		next_st.usb_irq = |(uotg_usb_view(st.usb_ir, st.err_sum, host_mode)
			& uotg_ie_view(st.usb_ie, host_mode));
		next_st.otg_irq = |(st.otg_ir & st.otg_ie);
		// address phase
		take = hsel & htrans[1] & hready;
		aidx = uotg_decode(haddr);
		rd = `UOTG_RST_BYTE;
		if (aidx == `UOTG_IDX_OTG_IR) begin
			rd = st.otg_ir;
		end else if (aidx == `UOTG_IDX_OTG_IE) begin
			rd = st.otg_ie;
		end else if (aidx == `UOTG_IDX_USB_IR) begin
			rd = uotg_usb_view(st.usb_ir, st.err_sum, host_mode);
		end else if (aidx == `UOTG_IDX_USB_IE) begin
			rd = uotg_ie_view(st.usb_ie, host_mode);
		end else if (aidx == `UOTG_IDX_ERR_IE) begin
			rd = st.err_ie;
		end
		if (take && hwrite) begin
			next_st.phase = UOTG_PH_WRITE;
			next_st.widx = aidx;
		end else if (take) begin
			next_st.phase = UOTG_PH_READ;
			next_st.rdata = {24'h000000, rd};
		end else begin
			next_st.phase = UOTG_PH_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// everything clears at reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign hrdata = st.rdata;
	assign hreadyout = st.ready;
	assign hresp = st.resp;
	assign usb_irq = st.usb_irq;
	assign otg_irq = st.otg_irq;
	assign fifo_advance = st.fifo_adv;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// stall flag follows a stall sent as peripheral
	AST_STALL_SET: assert property (
		(stall_sent && !host_mode) |=> st.usb_ir[7])
		else $error("stall flag not set");

	// clearing a pending token flag advances the fifo once
	AST_TOKEN_FIFO: assert property (
		(wr && st.widx == `UOTG_IDX_USB_IR && hwdata[3] && st.usb_ir[3])
		|=> fifo_advance ##1 !fifo_advance)
		else $error("fifo advance missing or long");

	// write one clears when no event competes
	AST_W1C_CLEAR: assert property (
		(wr && st.widx == `UOTG_IDX_USB_IR && hwdata[5] && !lif.resume_hit)
		|=> !st.usb_ir[5])
		else $error("write one did not clear");

	// write zero keeps, and set wins over clear
	AST_SET_WINS: assert property (
		(wr && st.widx == `UOTG_IDX_USB_IR && (!hwdata[5] || lif.resume_hit)
		&& (st.usb_ir[5] || lif.resume_hit)) |=> st.usb_ir[5])
		else $error("flag lost on write");

	// masked errors never raise the summary
	AST_ERR_MASKED: assert property (
		((err_flags & st.err_ie) == 8'h00) |=> !st.err_sum)
		else $error("masked error raised summary");

	// device-mode reads hide attach and upper bits
	AST_DEV_VIEW: assert property (
		(take && !hwrite && !host_mode && aidx == `UOTG_IDX_USB_IR)
		|=> hrdata[6] == 1'b0 && hrdata[31:8] == 24'h000000)
		else $error("device view shows host-only bit");

	// unimplemented enable bit stays zero
	AST_OTG_BIT1: assert property (
		(wr && st.widx == `UOTG_IDX_OTG_IE)
		|=> st.otg_ie[1] == 1'b0 && st.otg_ie == $past(hwdata[7:0] & 8'hfd))
		else $error("otg enable write wrong");

	// request follows enabled flags one cycle later
	AST_IRQ_OR: assert property (
		(|(st.otg_ir & st.otg_ie)) |=> otg_irq)
		else $error("otg request missing");

	// detach in host mode sets bit 0
	AST_DETACH: assert property (
		(lif.se0_hit && host_mode) |=> st.usb_ir[0])
		else $error("detach flag not set");

	// host frame threshold sets the frame flag
	AST_SOF_HOST: assert property (
		(host_mode && sof_thresh) |=> st.usb_ir[2])
		else $error("frame flag not set");

	COV_TOKEN_CLEAR: cover property (token_done ##[1:20] fifo_advance);
	COV_BUS_RESET: cover property (!host_mode && lif.se0_hit);
	COV_ATTACH: cover property (host_mode && lif.quiet_hit ##1 st.usb_ir[6]);
	COV_ERR_SUM: cover property (st.err_sum && usb_irq);
endmodule

`default_nettype wire

// ==== bench/uotg_usb_peer.sv ====
// far-side usb transceiver model driving the bus line levels
// assumes a commanded line mode from the bench, changed after hclk edges
`timescale 1ns/1ps
`default_nettype none

module uotg_usb_peer (
	// clock
	input wire logic hclk,
	// line control from the bench: 0 traffic, 1 j, 2 k, 3 se0
	input wire logic low_speed,
	input wire logic [1:0] drive_mode,
	// bus lines
	output logic line_dp,
	output logic line_dm
);
	logic ph = 1'b0;
	logic [1:0] j_lvl;

	// j is the idle level; k is its inverse
	assign j_lvl = low_speed ? 2'h1 : 2'h2;

	// drive the lines; traffic alternates j and k so no timer runs out
	always @(posedge hclk) begin
		ph <= ~ph;
		case (drive_mode)
			2'h0: {line_dp, line_dm} <= ph ? j_lvl : ~j_lvl;
			2'h1: {line_dp, line_dm} <= j_lvl;
			2'h2: {line_dp, line_dm} <= ~j_lvl;
			default: {line_dp, line_dm} <= 2'h0;
		endcase
	end
endmodule

`default_nettype wire

// ==== bench/usb_otg_interrupt_flags_tb.sv ====
// self-checking bench of the usb interrupt flag block over ahb-lite
// assumes uotg_regs.svh on the include path and a 25 MHz hclk
`timescale 1ns/1ps
`default_nettype none
`include "uotg_regs.svh"

module usb_otg_interrupt_flags_tb;
	logic hclk, hresetn, hsel, hwrite, host_mode, low_speed;
	logic rd_dp = 1'b0;
	logic line_dp, line_dm, hreadyout, hresp, usb_irq, otg_irq, fifo_advance;
	logic [1:0] htrans, drive_mode;
	logic [31:0] haddr, hwdata, hrdata, lfsr, v;
	logic [9:0] ev;
	logic [7:0] err_flags;
	logic [31:0] expq[$];
	int n_fail = 0, num_checks = 0, n_adv = 0, cyc = 0;
	int otg_ev[6] = '{4, 5, 6, 7, 8, 9};
	int otg_bit[6] = '{7, 6, 4, 3, 2, 0};

	// ----------------------------------------------------------------
	// design, far side and clock
	// ----------------------------------------------------------------
	uotg_irq_core #(.CYC_STABLE(17'h00028), .CYC_IDLE(17'h00064)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host_mode(host_mode),
		.low_speed(low_speed), .line_dp(line_dp), .line_dm(line_dm),
		.stall_sent(ev[0]), .token_done(ev[1]), .sof_rx(ev[2]), .sof_thresh(ev[3]),
		.id_change(ev[4]), .ms_tick(ev[5]), .bus_activity(ev[6]),
		.sess_valid_chg(ev[7]), .sess_end_chg(ev[8]), .vbus_valid_chg(ev[9]),
		.err_flags(err_flags), .usb_irq(usb_irq), .otg_irq(otg_irq),
		.fifo_advance(fifo_advance));
	uotg_usb_peer peer (.hclk(hclk), .low_speed(low_speed), .drive_mode(drive_mode),
		.line_dp(line_dp), .line_dm(line_dm));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// compare, report and bus tasks
	// ----------------------------------------------------------------
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_sig(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t output %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// one single transfer, entered right after a rising edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	// note the expected word, the monitor compares it
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		expq.push_back(exp);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic pulse(input logic [9:0] m);
		ev <= m;
		@(posedge hclk);
		ev <= 10'h000;
		@(posedge hclk);
	endtask

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// ----------------------------------------------------------------
	// monitor: read data phases, advance pulses, hang limit
	// ----------------------------------------------------------------
	always @(posedge hclk) begin
		if (rd_dp === 1'b1 && hreadyout === 1'b1)
			cmp_word(hrdata, expq.pop_front());
		if (fifo_advance === 1'b1)
			n_adv++;
		rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{hresetn, hsel, hwrite, host_mode, low_speed} = 5'h00;
		{htrans, drive_mode, ev, err_flags} = '0;
		haddr = 32'h0;
		hwdata = 32'h0;
		lfsr = 32'h220e;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// reset values, unmapped place, software cannot set flags
		for (int i = 0; i < 6; i++) rd(32'h4 * i, 32'h0);
		cmp_sig(hresp, 32'h0);
		wr(`UOTG_OFF_OTG_IR, 32'hffff_ffff);
		wr(`UOTG_OFF_USB_IR, 32'hffff_ffff);
		rd(`UOTG_OFF_OTG_IR, 32'h0);
		rd(`UOTG_OFF_USB_IR, 32'h0);
		cmp_sig(usb_irq | otg_irq, 32'h0);
		// random enable words in both modes
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			v = lfsr;
			host_mode <= i[0];
			wr(`UOTG_OFF_OTG_IE, v);
			rd(`UOTG_OFF_OTG_IE, v & 32'hfd);
			wr(`UOTG_OFF_USB_IE, v);
			rd(`UOTG_OFF_USB_IE, v & (i[0] ? 32'hff : 32'hbf));
			wr(`UOTG_OFF_ERR_IE, v);
			rd(`UOTG_OFF_ERR_IE, v & 32'hbf);
		end
		host_mode <= 1'b0;
		wr(`UOTG_OFF_OTG_IE, 32'h0);
		wr(`UOTG_OFF_USB_IE, 32'h0);
		wr(`UOTG_OFF_ERR_IE, 32'h0);
		// otg events, enable gating and clearing
		for (int i = 0; i < 6; i++) begin
			pulse(10'h001 << otg_ev[i]);
			rd(`UOTG_OFF_OTG_IR, 32'h1 << otg_bit[i]);
			cmp_sig(otg_irq, 32'h0);
			wr(`UOTG_OFF_OTG_IE, 32'h1 << otg_bit[i]);
			repeat (3) @(posedge hclk);
			cmp_sig(otg_irq, 32'h1);
			wr(`UOTG_OFF_OTG_IR, 32'hffff_ffff);
			rd(`UOTG_OFF_OTG_IR, 32'h0);
			wr(`UOTG_OFF_OTG_IE, 32'h0);
		end
		// device events, partial clear and status fifo advance
		pulse(10'h007);
		rd(`UOTG_OFF_USB_IR, 32'h8c);
		wr(`UOTG_OFF_USB_IE, 32'h08);
		repeat (3) @(posedge hclk);
		cmp_sig(usb_irq, 32'h1);
		wr(`UOTG_OFF_USB_IR, 32'h08);
		rd(`UOTG_OFF_USB_IR, 32'h84);
		cmp_sig(n_adv, 32'h1);
		cmp_sig(usb_irq, 32'h0);
		wr(`UOTG_OFF_USB_IR, 32'h08);
		@(posedge hclk);
		cmp_sig(n_adv, 32'h1);
		wr(`UOTG_OFF_USB_IR, 32'h84);
		rd(`UOTG_OFF_USB_IR, 32'h0);
		// host view: no stall flag, frame from threshold counter
		host_mode <= 1'b1;
		pulse(10'h009);
		rd(`UOTG_OFF_USB_IR, 32'h04);
		wr(`UOTG_OFF_USB_IR, 32'hff);
		wr(`UOTG_OFF_USB_IE, 32'hff);
		rd(`UOTG_OFF_USB_IE, 32'hff);
		host_mode <= 1'b0;
		rd(`UOTG_OFF_USB_IE, 32'hbf);
		wr(`UOTG_OFF_USB_IE, 32'h0);
		// error summary: masked, read-only, live
		err_flags <= 8'h44;
		wr(`UOTG_OFF_USB_IE, 32'h02);
		rd(`UOTG_OFF_USB_IR, 32'h0);
		wr(`UOTG_OFF_ERR_IE, 32'h40);
		rd(`UOTG_OFF_USB_IR, 32'h0);
		wr(`UOTG_OFF_ERR_IE, 32'h04);
		@(posedge hclk); // summary follows the enable one cycle later
		rd(`UOTG_OFF_USB_IR, 32'h02);
		wr(`UOTG_OFF_USB_IR, 32'h02);
		rd(`UOTG_OFF_USB_IR, 32'h02);
		cmp_sig(usb_irq, 32'h1);
		err_flags <= 8'h00;
		repeat (2) @(posedge hclk);
		rd(`UOTG_OFF_USB_IR, 32'h0);
		cmp_sig(usb_irq, 32'h0);
		wr(`UOTG_OFF_ERR_IE, 32'h0);
		// bus reset once per reset state
		drive_mode <= 2'h3;
		repeat (80) @(posedge hclk);
		rd(`UOTG_OFF_USB_IR, 32'h01);
		wr(`UOTG_OFF_USB_IR, 32'h01);
		repeat (80) @(posedge hclk);
		rd(`UOTG_OFF_USB_IR, 32'h0);
		// resume at low and full speed polarity
		for (int s = 1; s >= 0; s--) begin
			drive_mode <= 2'h0;
			low_speed <= s[0];
			repeat (5) @(posedge hclk);
			drive_mode <= 2'h2;
			repeat (80) @(posedge hclk);
			rd(`UOTG_OFF_USB_IR, 32'h20);
			wr(`UOTG_OFF_USB_IR, 32'hdf);
			rd(`UOTG_OFF_USB_IR, 32'h20);
			wr(`UOTG_OFF_USB_IR, 32'h20);
		end
		// idle and line stable; attach stays hidden in device mode
		drive_mode <= 2'h0;
		wr(`UOTG_OFF_OTG_IR, 32'hff);
		drive_mode <= 2'h1;
		repeat (130) @(posedge hclk);
		rd(`UOTG_OFF_USB_IR, 32'h10);
		rd(`UOTG_OFF_OTG_IR, 32'h20);
		// host attach then detach
		host_mode <= 1'b1;
		drive_mode <= 2'h0;
		repeat (10) @(posedge hclk);
		wr(`UOTG_OFF_USB_IR, 32'hff);
		drive_mode <= 2'h1;
		repeat (75) @(posedge hclk);
		rd(`UOTG_OFF_USB_IR, 32'h40);
		drive_mode <= 2'h3;
		repeat (80) @(posedge hclk);
		rd(`UOTG_OFF_USB_IR, 32'h41);
		repeat (4) @(posedge hclk);
		cmp_sig(expq.size(), 32'h0);
		final_report();
	end
endmodule

`default_nettype wire
